// [inc/srfp_pkg.sv]
// Package for the status record field packer
`default_nettype none
package srfp_pkg;
  // ----------------------------------------------------------------
  // Register offsets (32-bit word addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL    = 4'h0;
  localparam logic [3:0] OFS_STATUS  = 4'h1;
  localparam logic [3:0] OFS_MASK    = 4'h2;
  localparam logic [3:0] OFS_SWITCH  = 4'h3;
  localparam logic [3:0] OFS_AMP     = 4'h4;
  localparam logic [3:0] OFS_VEL     = 4'h5;
  localparam logic [3:0] OFS_TORQUE  = 4'h6;
  localparam logic [3:0] OFS_LAYOUT  = 4'h7;
  localparam logic [3:0] OFS_HEADER  = 4'h8;
  localparam logic [3:0] OFS_TVIN    = 4'h9;
  localparam logic [3:0] OFS_TQIN    = 4'hA;
  localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SW_LATCH_OCC = 7;
  localparam int SW_LATCH_IN  = 6;
  localparam int SW_FWD       = 3;
  localparam int SW_REV       = 2;
  localparam int SW_HOME      = 1;
  localparam int SW_STEP      = 0;
  localparam int AMP_ELO      = 24;
  localparam int AMP_PEAK     = 16;
  localparam int AMP_HALL     = 8;
  localparam int AMP_UV       = 3;
  localparam int AMP_OT       = 2;
  localparam int AMP_OV       = 1;
  localparam int AMP_OC       = 0;
  localparam int VEL_SHIFT    = 6;
  localparam int NUM_EVT      = 2;
  localparam int EVT_LATCH    = 0;
  localparam int EVT_FAULT    = 1;
  localparam int CTRL_CLR_LATCH = 0;
  // ----------------------------------------------------------------
  // Record constants
  // ----------------------------------------------------------------
  localparam logic signed [31:0] TQ_MAX = 32'sh0000_7FFF;
  localparam logic signed [31:0] TQ_MIN = -32'sh0000_7FFF;
  localparam logic [7:0] LAY_AXES   = 8'h01;
  localparam logic [7:0] LAY_GEN    = 8'h12;
  localparam logic [7:0] LAY_PLANE  = 8'h10;
  localparam logic [7:0] LAY_AXIS   = 8'h24;
  localparam logic [7:0] HDR_LEN_LO = 8'h4A;
  localparam logic [7:0] HDR_LEN_HI = 8'h00;
  localparam logic [7:0] HDR_BYTE0  = 8'h01;
  localparam logic [7:0] HDR_BYTE1  = 8'h81;
  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic latchIn;
    logic fwdLimit;
    logic revLimit;
    logic homeIn;
    logic stepperMode;
  } srfp_sw_in_t;
  typedef struct packed {
    logic eloActive;
    logic peakCurrent;
    logic hallError;
    logic underVolt;
    logic overTemp;
    logic overVolt;
    logic overCurrent;
  } srfp_amp_in_t;
endpackage
`default_nettype wire

// [design/srfp_torque_clamp.sv]
// Signed torque saturation to the record range
`default_nettype none
module srfp_torque_clamp (
  input  wire logic signed [31:0] rawTorque,
  output var  logic signed [31:0] clampedTorque
);
  // ----------------------------------------------------------------
  // Clamp
  // ----------------------------------------------------------------
  // clamp to range
  always_comb begin
    if (rawTorque > srfp_pkg::TQ_MAX) begin
      clampedTorque = srfp_pkg::TQ_MAX;
    end else if (rawTorque < srfp_pkg::TQ_MIN) begin
      clampedTorque = srfp_pkg::TQ_MIN;
    end else begin
      clampedTorque = rawTorque;
    end
  end
endmodule
`default_nettype wire

// [design/srfp_word_pack.sv]
// Switch byte and amplifier word assembly
`default_nettype none
module srfp_word_pack (
  input  wire logic                 latchOccurred,
  input  wire srfp_pkg::srfp_sw_in_t  swIn,
  input  wire srfp_pkg::srfp_amp_in_t ampIn,
  output var  logic [7:0]           switchByte,
  output var  logic [31:0]          ampWord
);
  // ----------------------------------------------------------------
  // Packing
  // ----------------------------------------------------------------
  // switch byte layout
  always_comb begin
    switchByte = 8'h00;
    switchByte[srfp_pkg::SW_LATCH_OCC] = latchOccurred;
    switchByte[srfp_pkg::SW_LATCH_IN]  = swIn.latchIn;
    switchByte[srfp_pkg::SW_FWD]       = swIn.fwdLimit;
    switchByte[srfp_pkg::SW_REV]       = swIn.revLimit;
    switchByte[srfp_pkg::SW_HOME]      = swIn.homeIn;
    switchByte[srfp_pkg::SW_STEP]      = swIn.stepperMode;
  end
  always_comb begin
    ampWord = 32'h0000_0000;
    ampWord[srfp_pkg::AMP_ELO]  = ampIn.eloActive;
    ampWord[srfp_pkg::AMP_PEAK] = ampIn.peakCurrent;
    ampWord[srfp_pkg::AMP_HALL] = ampIn.hallError;
    ampWord[srfp_pkg::AMP_UV]   = ampIn.underVolt;
    ampWord[srfp_pkg::AMP_OT]   = ampIn.overTemp;
    ampWord[srfp_pkg::AMP_OV]   = ampIn.overVolt;
    ampWord[srfp_pkg::AMP_OC]   = ampIn.overCurrent;
  end
endmodule
`default_nettype wire

// [design/srfp_top.sv]
// Status record field packer with Avalon-MM register slave
// Overview of operation
// - Switch byte: latch, limits, home, stepper bits
// - Amplifier word: lockout, peak, hall, supply faults
// - Record velocity is sixty-four times interrogated
// - Torque clamped to plus/minus 32767
// - Layout query returns four descriptor bytes
// - Descriptor byte 0 holds axis count 1
// - Descriptor byte 1 holds general length 18
// - Descriptor byte 2 holds plane length 16
// - Descriptor byte 3 holds axis length 36
// - Header bytes 2,3 carry length, low first
// - Header fields sent little-endian
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`default_nettype none
module srfp_top (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic [3:0]             address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [31:0]            writedata,
  input  wire logic [3:0]             byteenable,
  output logic [31:0]                 readdata,
  output logic                        waitrequest,
  input  wire srfp_pkg::srfp_sw_in_t  swIn,
  input  wire logic                   latchEvent,
  input  wire srfp_pkg::srfp_amp_in_t ampIn,
  input  wire logic signed [31:0]     velIn,
  input  wire logic signed [31:0]     torqueIn,
  output logic                        irq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic                            latchOcc_reg;
  logic [srfp_pkg::NUM_EVT-1:0]    status_reg;
  logic [srfp_pkg::NUM_EVT-1:0]    mask_reg;
  logic [srfp_pkg::NUM_EVT-1:0]    evt;
  logic [7:0]                      switchByte;
  logic [31:0]                     ampWord;
  logic [31:0]                     ampPrev_reg;
  logic signed [31:0]              torqueClamp;
  logic signed [31:0]              recVel;
  logic [31:0]                     rdMux;
  logic                            done_reg;
  logic                            access;
  logic                            wrHit;
  logic                            rdDone;

  assign access = (read | write) & ~done_reg;
  assign wrHit  = write & ~done_reg & byteenable[0];

  // ----------------------------------------------------------------
  // Field packers
  // ----------------------------------------------------------------
  srfp_word_pack uPack (
    .latchOccurred (latchOcc_reg),
    .swIn          (swIn),
    .ampIn         (ampIn),
    .switchByte    (switchByte),
    .ampWord       (ampWord)
  );

  srfp_torque_clamp uClamp (
    .rawTorque     (torqueIn),
    .clampedTorque (torqueClamp)
  );

  assign recVel = velIn <<< srfp_pkg::VEL_SHIFT;

  // ----------------------------------------------------------------
  // Latch occurred flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latchOcc_reg <= 1'b0;
    end else if (latchEvent) begin
      latchOcc_reg <= 1'b1;
    end else if (wrHit && address == srfp_pkg::OFS_CTRL &&
                 writedata[srfp_pkg::CTRL_CLR_LATCH]) begin
      latchOcc_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ampPrev_reg <= 32'h0000_0000;
    end else begin
      ampPrev_reg <= ampWord;
    end
  end

  assign evt[srfp_pkg::EVT_LATCH] = latchEvent;
  assign evt[srfp_pkg::EVT_FAULT] = |(ampWord & ~ampPrev_reg);

  generate
    for (genvar i = 0; i < srfp_pkg::NUM_EVT; i++) begin : gEvt
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          status_reg[i] <= 1'b0;
        end else if (evt[i]) begin
          status_reg[i] <= 1'b1;
        end else if (wrHit && address == srfp_pkg::OFS_STATUS &&
                     writedata[i]) begin
          status_reg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mask_reg <= '0;
    end else if (wrHit && address == srfp_pkg::OFS_MASK) begin
      mask_reg <= writedata[srfp_pkg::NUM_EVT-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  always_comb begin
    rdMux = srfp_pkg::UNMAPPED_VAL;
    case (address)
      srfp_pkg::OFS_CTRL:   rdMux = {31'h0, latchOcc_reg};
      srfp_pkg::OFS_STATUS: rdMux = {30'h0, status_reg};
      srfp_pkg::OFS_MASK:   rdMux = {30'h0, mask_reg};
      srfp_pkg::OFS_SWITCH: rdMux = {24'h0, switchByte};
      srfp_pkg::OFS_AMP:    rdMux = ampWord;
      srfp_pkg::OFS_VEL:    rdMux = recVel;
      srfp_pkg::OFS_TORQUE: rdMux = torqueClamp;
      srfp_pkg::OFS_LAYOUT: rdMux = {srfp_pkg::LAY_AXIS,
                                     srfp_pkg::LAY_PLANE,
                                     srfp_pkg::LAY_GEN,
                                     srfp_pkg::LAY_AXES};
      srfp_pkg::OFS_HEADER: rdMux = {srfp_pkg::HDR_LEN_HI,
                                     srfp_pkg::HDR_LEN_LO,
                                     srfp_pkg::HDR_BYTE1,
                                     srfp_pkg::HDR_BYTE0};
      srfp_pkg::OFS_TVIN:   rdMux = velIn;
      srfp_pkg::OFS_TQIN:   rdMux = torqueIn;
      default:              rdMux = srfp_pkg::UNMAPPED_VAL;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  assign rdDone = read & ~done_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= access;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~access;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      readdata <= 32'h0000_0000;
    end else if (rdDone) begin
      readdata <= rdMux;
    end
  end
endmodule
`default_nettype wire

// [tb/srfp_props.sv]
// Port checker for the status record field packer
`default_nettype none
module srfp_props (
  input wire logic                   clk,
  input wire logic                   nrst,
  input wire logic [3:0]             address,
  input wire logic                   read,
  input wire logic                   write,
  input wire logic [31:0]            readdata,
  input wire logic                   waitrequest,
  input wire srfp_pkg::srfp_sw_in_t  swIn,
  input wire srfp_pkg::srfp_amp_in_t ampIn,
  input wire logic signed [31:0]     velIn,
  input wire logic signed [31:0]     torqueIn
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_rd(logic [3:0] a);
    read && address == a ##1 !waitrequest;
  endsequence
  property p_ans;
    $rose(read || write) |=> !waitrequest;
  endproperty
  property p_one;
    !waitrequest |=> waitrequest;
  endproperty
  property p_sw;
    s_rd(4'h3) |-> readdata[31:8] == 24'h0 && readdata[6:0] ==
      {$past(swIn.latchIn), 2'h0, $past(swIn[3:0])};
  endproperty
  property p_amp;
    s_rd(4'h4) |-> readdata == {7'h0, $past(ampIn[6]), 7'h0,
      $past(ampIn[5]), 7'h0, $past(ampIn[4]), 4'h0, $past(ampIn[3:0])};
  endproperty
  property p_vel;
    s_rd(4'h5) |-> readdata == {$past(velIn[25:0]), 6'h00};
  endproperty
  property p_tq;
    s_rd(4'h6) |-> readdata == ($past(torqueIn) > 32'sh7FFF ? 32'sh7FFF :
      $past(torqueIn) < -32'sh7FFF ? -32'sh7FFF : $past(torqueIn));
  endproperty
  property p_lay;
    s_rd(4'h7) |-> readdata == 32'h2410_1201;
  endproperty
  property p_hdr;
    s_rd(4'h8) |-> readdata[31:16] == 16'h004A;
  endproperty
  a_ans: assert property (p_ans)
    else $error("no answer after request");
  a_one: assert property (p_one)
    else $error("wait low too long");
  a_sw: assert property (p_sw)
    else $error("switch byte wrong");
  a_amp: assert property (p_amp)
    else $error("amplifier word wrong");
  a_vel: assert property (p_vel)
    else $error("velocity scale wrong");
  a_tq: assert property (p_tq)
    else $error("torque clamp wrong");
  a_lay: assert property (p_lay)
    else $error("layout bytes wrong");
  a_hdr: assert property (p_hdr)
    else $error("header length wrong");
endmodule
`default_nettype wire

// [tb/srfp_host.sv]
// Host model issuing Avalon-MM transfers
`default_nettype none
module srfp_host (
  input  wire logic        clk,
  input  wire logic        waitrequest,
  input  wire logic [31:0] readdata,
  output var  logic [3:0]  address,
  output var  logic        read,
  output var  logic        write,
  output var  logic [31:0] writedata,
  output var  logic [3:0]  byteenable
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {address, read, write, writedata, byteenable} = '0;
  end
  task automatic xfer(input logic w, input logic [3:0] a,
    input logic [31:0] d, input logic [3:0] be, output logic [31:0] q);
    @(posedge clk);
    address    <= a;
    read       <= !w;
    write      <= w;
    writedata  <= d;
    byteenable <= be;
    @(posedge clk);
    while (waitrequest !== 1'b0) @(posedge clk);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/srfp_bench.sv]
// Bench for the status record field packer
`default_nettype none
module srfp_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0] a; logic [4:0] s; logic [6:0] m;
    logic [31:0] v; logic [31:0] t; logic [31:0] e;
  } srfp_row_t;
  srfp_row_t rows [11] = '{
    '{4'h3, 5'h1F, 7'h00, 32'h0, 32'h0, 32'h4F},
    '{4'h3, 5'h0A, 7'h00, 32'h0, 32'h0, 32'h0A},
    '{4'h4, 5'h00, 7'h7F, 32'h0, 32'h0, 32'h0101_010F},
    '{4'h4, 5'h00, 7'h05, 32'h0, 32'h0, 32'h5},
    '{4'h5, 5'h00, 7'h05, 32'h3, 32'h0, 32'hC0},
    '{4'h5, 5'h00, 7'h05, 32'hFFFF_FFFF, 32'h0, 32'hFFFF_FFC0},
    '{4'h6, 5'h00, 7'h05, 32'h0, 32'h9C40, 32'h7FFF},
    '{4'h6, 5'h00, 7'h05, 32'h0, 32'hFFFF_63C0, 32'hFFFF_8001},
    '{4'h6, 5'h00, 7'h05, 32'h0, 32'hFFFF_8001, 32'hFFFF_8001},
    '{4'h7, 5'h00, 7'h05, 32'h0, 32'h0, 32'h2410_1201},
    '{4'h8, 5'h00, 7'h05, 32'h0, 32'h0, 32'h004A_8101}};
  logic clk = 1'b0, nrst = 1'b0, latchEvent = 1'b0, read, write, wr, irq;
  logic [3:0] address, byteenable;
  logic [31:0] writedata, readdata, q;
  logic signed [31:0] velIn = '0, torqueIn = '0;
  srfp_pkg::srfp_sw_in_t swIn = '0;
  srfp_pkg::srfp_amp_in_t ampIn = '0;
  int failures = 0, comparisons = 0, cycles = 0;
  srfp_top i_srfp_top (.clk(clk), .nrst(nrst), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(wr),
    .swIn(swIn), .latchEvent(latchEvent), .ampIn(ampIn), .velIn(velIn),
    .torqueIn(torqueIn), .irq(irq));
  srfp_host i_srfp_host (.clk(clk), .waitrequest(wr), .readdata(readdata),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic close_out;
    if (failures == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    i_srfp_host.xfer(1'b0, a, 32'h0, 4'hF, q);
    chk("readdata", e, q);
  endtask
  task automatic wt(input logic [3:0] a, d, be);
    i_srfp_host.xfer(1'b1, a, {28'h0, d}, be, q);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      close_out();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    chk("reset", 32'h1, {readdata[30:0], wr | irq});
    nrst <= 1'b1;
    foreach (rows[i]) begin
      @(posedge clk);
      {swIn, ampIn, velIn, torqueIn} <=
        {rows[i].s, rows[i].m, rows[i].v, rows[i].t};
      rd(rows[i].a, rows[i].e);
    end
    rd(4'h1, 32'h2);
    wt(4'h2, 4'h3, 4'hF);
    irq_is(1'b1);
    wt(4'h1, 4'h2, 4'hF);
    irq_is(1'b0);
    wt(4'h2, 4'h0, 4'h0);
    rd(4'h2, 32'h3);
    latchEvent <= 1'b1;
    @(posedge clk);
    latchEvent <= 1'b0;
    irq_is(1'b1);
    rd(4'h3, 32'h80);
    rd(4'h0, 32'h1);
    wt(4'h0, 4'h1, 4'hF);
    rd(4'h3, 32'h0);
    wt(4'h1, 4'h1, 4'hF);
    irq_is(1'b0);
    rd(4'hF, 32'h0);
    close_out();
  end
endmodule
bind srfp_top srfp_props i_props (.clk(clk), .nrst(nrst),
  .address(address), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .swIn(swIn), .ampIn(ampIn), .velIn(velIn),
  .torqueIn(torqueIn));
`default_nettype wire
